// file: src/ssp_top.sv
// ssp_top: synchronous serial port, master or slave, with Wishbone registers
// assumes a classic Wishbone master on clk_i and pins that the bench resolves
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (R1) master clock toggles only during a byte
// (R2) eight bits out and in per transfer
// (R3) bit order: 0 msb first, 1 lsb first
// (R4) data write while busy ignored, sets collision
// (R5) slave byte while done flag set: overflow
// (R6) overflow reads zero in master role
// (R7) slave to master switch clears overflow
// (R8) done flag set after last bit
// (R9) flags clear: status read, then data access
// (R10) collision and overflow raise no request
// (R11) software keeps mode-fault bit at one
// (R12) disable takes effect after current transfer
// (R13) software picks role before enabling
// (R14) polarity sets idle clock level
// (R15) master rate: divide by 4/8/16/64
// (R16) slave uses external clock, ignores rate
// (R17) external master keeps rate in range
// (R18) master starts transfer on data write
// (R19) software waits for done before next write
// (R20) software writes whole control byte
// (R21) software sets shared port latches high
// (R22) request pulse when done flag rises
// (R23) shift on one edge, sample on other
// (R24) deselected slave ignores clock and data
// (R25) shift register ends holding received byte
// (R26) data read gives received, write loads
module ssp_top #(
   parameter int ADR_W = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [ssp_pkg::WB_DW-1:0] wb_dat_i,
   output logic [ssp_pkg::WB_DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   // serial clock pin
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe_o,
   // master-out data pin
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_o,
   // master-in data pin
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_o,
   // slave select, active low
   input wire logic ss_n_i,
   // transfer done request
   output logic serial_done_irq_o
);
   import ssp_pkg::*;

   if (ADR_W < 8) begin : g_chk
      $error("ssp_top: ADR_W must be at least 8");
   end

   // ==================================================
   // state
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_MASTER,
      PH_SLAVE
   } ssp_phase_t;

   typedef struct packed {
      ssp_phase_t phase;
      ssp_ctrl_t ctrl;
      logic [7:0] sr;
      logic rxb;
      logic dout;
      logic sclk;
      logic m_lead;
      logic m_trail;
      logic setup;
      logic [2:0] bitcnt;
      logic transfer_done_flag;
      logic write_collision_flag;
      logic slave_overflow_flag;
      logic [2:0] armed;
      logic sclk_d;
      logic irq;
      logic ack;
      logic [7:0] rdat;
   } ssp_state_t;

   ssp_state_t s;
   ssp_state_t next_s;

   // ==================================================
   // helpers
   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
      shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   function automatic logic out_bit(input logic [7:0] v, input logic lsb);
      out_bit = lsb ? v[0] : v[7];
   endfunction

   // ==================================================
   // divider and pin synchroniser
   ssp_link_if link();

   ssp_clkgen #(
      .CNT_W(6)
   ) u_clkgen (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .link(link.clkgen)
   );

   ssp_sync #(
      .W(4),
      .RST_VAL(PINS_RST)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .link(link.sync)
   );

   logic p_sclk;
   logic p_mosi;
   logic p_miso;
   logic p_ss_n;

   assign link.raw = {ss_n_i, miso_i, mosi_i, sclk_i};
   assign p_sclk = link.synced[PIN_SCLK];
   assign p_mosi = link.synced[PIN_MOSI];
   assign p_miso = link.synced[PIN_MISO];
   assign p_ss_n = link.synced[PIN_SS];
   assign link.rate = s.ctrl.rate; // R15
   assign link.run = (s.phase == PH_MASTER); // R16

   // ==================================================
   // next state
   logic req;
   logic [ADR_W-3:0] word;
   logic hit_sts;
   logic hit_data;
   logic hit_ctrl;
   logic wr_lane;
   logic busy_wr;
   logic lead;
   logic trail;
   logic sel;
   logic in_bit;
   logic set_sef;
   logic set_write_collision_flag;
   logic set_slave_overflow_flag;
   logic clr;
   logic clr_role;
   logic [7:0] sts;
   logic [7:0] wdat;
   logic [7:0] shifted;
   ssp_ctrl_t new_ctrl;

   always_comb begin
      next_s = s;
      next_s.irq = 1'b0;
      set_sef = 1'b0;
      set_write_collision_flag = 1'b0;
      set_slave_overflow_flag = 1'b0;
      clr = 1'b0;
      clr_role = 1'b0;
      lead = 1'b0;
      trail = 1'b0;
      shifted = s.sr;
      wdat = wb_dat_i[7:0];
      new_ctrl = wb_dat_i[7:0];

      // idle levels follow the control register
      if (s.phase == PH_IDLE) begin
         next_s.sclk = s.ctrl.cpol; // R1 R14
         next_s.dout = out_bit(s.sr, s.ctrl.bit_order_select); // R23
      end

      // ---------------- bus slave
      req = wb_cyc_i & wb_stb_i & ~s.ack;
      word = wb_adr_i[ADR_W-1:ADR_LSB];
      hit_sts = req & (word == (ADR_W-2)'(IDX_STATUS));
      hit_data = req & (word == (ADR_W-2)'(IDX_DATA));
      hit_ctrl = req & (word == (ADR_W-2)'(IDX_CONTROL));
      wr_lane = wb_we_i & wb_sel_i[0];
      sts = 8'h00;
      sts[STS_SEF] = s.transfer_done_flag;
      sts[STS_WRITE_COLLISION_FLAG] = s.write_collision_flag;
      sts[STS_SLAVE_OVERFLOW_FLAG] = s.slave_overflow_flag & ~s.ctrl.role_select; // R6
      busy_wr = (s.phase != PH_IDLE) |
         (~s.ctrl.role_select & ~s.ctrl.cpha & s.ctrl.see & ~p_ss_n);
      next_s.ack = req;
      if (req) begin
         next_s.rdat = 8'h00;
      end
      if (hit_sts & ~wb_we_i) begin
         next_s.rdat = sts;
         next_s.armed = {sts[STS_SEF], sts[STS_WRITE_COLLISION_FLAG], sts[STS_SLAVE_OVERFLOW_FLAG]}; // R9
      end
      if (hit_ctrl) begin
         if (wb_we_i) begin
            if (wr_lane) begin
               next_s.ctrl = new_ctrl; // R11 R12 R13 R20
               if (~s.ctrl.role_select & new_ctrl.role_select) begin
                  clr_role = 1'b1; // R7
               end
            end
         end else begin
            next_s.rdat = s.ctrl;
         end
      end
      if (hit_data) begin
         clr = 1'b1; // R9
         if (wb_we_i) begin
            if (wr_lane) begin
               if (busy_wr) begin
                  set_write_collision_flag = 1'b1; // R4
               end else begin
                  next_s.sr = wdat; // R26
                  next_s.dout = out_bit(wdat, s.ctrl.bit_order_select);
                  if (s.ctrl.see & s.ctrl.role_select) begin
                     next_s.phase = PH_MASTER; // R18
                     next_s.setup = 1'b0;
                     next_s.bitcnt = 3'h0;
                     next_s.sclk = s.ctrl.cpol;
                  end
               end
            end
         end else begin
            next_s.rdat = s.sr; // R26
         end
      end

      // ---------------- master clock edges
      // core acts one cycle after the pin edge, so miso has crossed its synchroniser even at divide by 4
      next_s.m_lead = 1'b0;
      next_s.m_trail = 1'b0;
      if (s.phase == PH_MASTER) begin
         lead = s.m_lead; // R23
         trail = s.m_trail;
      end
      if (s.phase == PH_MASTER && link.tick) begin
         if (!s.setup) begin
            next_s.setup = 1'b1; // R23
         end else begin
            next_s.m_lead = (s.sclk == s.ctrl.cpol);
            next_s.m_trail = (s.sclk != s.ctrl.cpol);
            next_s.sclk = ~s.sclk; // R1
         end
      end

      // ---------------- slave clock edges
      next_s.sclk_d = p_sclk;
      sel = ~s.ctrl.role_select & ~p_ss_n & (s.phase != PH_MASTER) &
         (s.ctrl.see | (s.phase == PH_SLAVE)); // R12 R24
      if (s.phase == PH_SLAVE && p_ss_n) begin
         next_s.phase = PH_IDLE; // R24
      end else if (sel && p_sclk != s.sclk_d) begin
         lead = (p_sclk != s.ctrl.cpol); // R16
         trail = ~lead;
         if (s.phase == PH_IDLE) begin
            if (lead) begin
               next_s.phase = PH_SLAVE;
               next_s.bitcnt = 3'h0;
            end else begin
               trail = 1'b0;
            end
         end
      end

      // ---------------- shift core
      in_bit = (s.phase == PH_MASTER) ? p_miso : p_mosi;
      if (lead) begin
         if (s.ctrl.cpha) begin
            next_s.dout = out_bit(s.sr, s.ctrl.bit_order_select); // R23 R3
         end else begin
            next_s.rxb = in_bit; // R23
         end
      end
      if (trail) begin
         shifted = shift_in(s.sr, s.ctrl.cpha ? in_bit : s.rxb, s.ctrl.bit_order_select); // R3 R25
         next_s.sr = shifted;
         if (!s.ctrl.cpha) begin
            next_s.dout = out_bit(shifted, s.ctrl.bit_order_select);
         end
         next_s.bitcnt = 3'(s.bitcnt + 1'b1); // R2
         if (s.bitcnt == BIT_LAST) begin
            next_s.phase = PH_IDLE; // R2 R12
            set_sef = 1'b1; // R8
            if (s.phase == PH_SLAVE && s.transfer_done_flag) begin
               set_slave_overflow_flag = 1'b1; // R5
            end
         end
      end

      // ---------------- flags, set wins over clear
      next_s.transfer_done_flag = set_sef | (s.transfer_done_flag & ~(clr & s.armed[2])); // R9
      next_s.write_collision_flag = set_write_collision_flag | (s.write_collision_flag & ~(clr & s.armed[1])); // R9
      next_s.slave_overflow_flag = set_slave_overflow_flag | (s.slave_overflow_flag & ~(clr & s.armed[0]) & ~clr_role); // R7 R9
      if (clr) begin
         next_s.armed = 3'h0;
      end
      next_s.irq = set_sef & ~s.transfer_done_flag; // R10 R22
   end

   // ==================================================
   // registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.phase <= PH_IDLE;
         s.ctrl <= CONTROL_RST;
         s.sr <= DATA_RST;
      end else begin
         s <= next_s;
      end
   end

   // ==================================================
   // outputs
   logic active;

   assign active = s.ctrl.see | (s.phase != PH_IDLE); // R12
   assign wb_ack_o = s.ack;
   assign wb_dat_o = {24'h00_0000, s.rdat};
   assign sclk_o = s.sclk;
   assign sclk_oe_o = active & s.ctrl.role_select;
   assign mosi_o = s.dout;
   assign mosi_oe_o = active & s.ctrl.role_select;
   assign miso_o = s.dout;
   assign miso_oe_o = active & ~s.ctrl.role_select;
   assign serial_done_irq_o = s.irq;
endmodule
`default_nettype wire

// file: shared/ssp_pkg.sv
// ssp_pkg: register map, field layout and timing constants of the serial port
// assumes a 32-bit classic Wishbone bus with one aligned word per register
package ssp_pkg;
   // ==================================================
   // bus and register map
   localparam int WB_DW = 32;
   localparam int ADR_LSB = 2;
   // register index, byte address is four times the index
   localparam logic [5:0] IDX_STATUS = 6'h28;
   localparam logic [5:0] IDX_DATA = 6'h29;
   localparam logic [5:0] IDX_CONTROL = 6'h2a;

   // ==================================================
   // status bit positions
   localparam int STS_SEF = 7;
   localparam int STS_WRITE_COLLISION_FLAG = 6;
   localparam int STS_SLAVE_OVERFLOW_FLAG = 5;

   // ==================================================
   // control layout, msb first
   typedef struct packed {
      logic mode;
      logic see;
      logic bit_order_select;
      logic role_select;
      logic cpol;
      logic cpha;
      logic [1:0] rate;
   } ssp_ctrl_t;
   localparam ssp_ctrl_t CONTROL_RST = 8'h04;
   localparam logic [7:0] DATA_RST = 8'h00;

   // ==================================================
   // rate codes and serial half periods in system clocks
   localparam logic [1:0] RATE_DIV4 = 2'h0;
   localparam logic [1:0] RATE_DIV8 = 2'h1;
   localparam logic [1:0] RATE_DIV16 = 2'h2;
   localparam logic [1:0] RATE_DIV64 = 2'h3;
   localparam logic [5:0] HALF_DIV4 = 6'h02;
   localparam logic [5:0] HALF_DIV8 = 6'h04;
   localparam logic [5:0] HALF_DIV16 = 6'h08;
   localparam logic [5:0] HALF_DIV64 = 6'h20;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // ==================================================
   // pin vector through the synchroniser
   localparam int PIN_SCLK = 0;
   localparam int PIN_MOSI = 1;
   localparam int PIN_MISO = 2;
   localparam int PIN_SS = 3;
   localparam logic [3:0] PINS_RST = 4'h8;
endpackage

// file: shared/ssp_link_if.sv
// ssp_link_if: signals between the port core, its divider and its synchroniser
// assumes all three parties share one clock
`timescale 1ns/100ps
`default_nettype none
interface ssp_link_if;
   logic [1:0] rate;
   logic run;
   logic tick;
   logic [3:0] raw;
   logic [3:0] synced;
   modport core (output rate, output run, output raw, input tick, input synced);
   modport clkgen (input rate, input run, output tick);
   modport sync (input raw, output synced);
endinterface
`default_nettype wire

// file: src/ssp_clkgen.sv
// ssp_clkgen: half-period tick generator for the master serial clock
// assumes run stays high for the whole transfer
`timescale 1ns/100ps
`default_nettype none
module ssp_clkgen #(
   parameter int CNT_W = 6
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // core side
   ssp_link_if.clkgen link
);
   import ssp_pkg::*;

   if (CNT_W < 6) begin : g_chk
      $error("ssp_clkgen: CNT_W must be at least 6");
   end

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic tick;
   } ssp_div_t;

   ssp_div_t s;
   ssp_div_t next_s;
   logic [CNT_W-1:0] half;

   always_comb begin
      unique case (link.rate)
         RATE_DIV4: half = CNT_W'(HALF_DIV4);
         RATE_DIV8: half = CNT_W'(HALF_DIV8);
         RATE_DIV16: half = CNT_W'(HALF_DIV16);
         RATE_DIV64: half = CNT_W'(HALF_DIV64);
      endcase
      next_s = s;
      next_s.tick = 1'b0;
      if (!link.run) begin
         next_s.cnt = '0;
      end else if (s.cnt == CNT_W'(half - 1'b1)) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = CNT_W'(s.cnt + 1'b1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign link.tick = s.tick;
endmodule
`default_nettype wire

// file: src/ssp_sync.sv
// ssp_sync: two-stage synchroniser for the serial pins
// assumes pins are asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module ssp_sync #(
   parameter int W = 4,
   parameter logic [3:0] RST_VAL = 4'h0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // core side
   ssp_link_if.sync link
);
   if (W < 1 || W > 4) begin : g_chk
      $error("ssp_sync: W must be 1 to 4");
   end

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } ssp_sync_t;

   ssp_sync_t s;
   ssp_sync_t next_s;

   always_comb begin
      next_s.meta = link.raw[W-1:0];
      next_s.stable = s.meta;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= {RST_VAL[W-1:0], RST_VAL[W-1:0]};
      end else begin
         s <= next_s;
      end
   end

   assign link.synced = 4'(s.stable);
endmodule
`default_nettype wire

// file: sim/ssp_checker.sv
// ssp_checker: port-level checks of ssp_top
// assumes it is bound to ssp_top and sees one clock domain
`timescale 1ns/100ps
`default_nettype none
module ssp_checker #(
   parameter int ADR_W = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [ssp_pkg::WB_DW-1:0] wb_dat_i,
   input wire logic [ssp_pkg::WB_DW-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   // pins
   input wire logic sclk_i,
   input wire logic sclk_o,
   input wire logic sclk_oe_o,
   input wire logic mosi_i,
   input wire logic mosi_o,
   input wire logic mosi_oe_o,
   input wire logic miso_i,
   input wire logic miso_o,
   input wire logic miso_oe_o,
   input wire logic ss_n_i,
   input wire logic serial_done_irq_o
);
   import ssp_pkg::*;
   typedef struct packed {
      logic [7:0] ctl;
      logic [6:0] gap;
      logic [4:0] ne;
      logic sc;
   } ssp_chk_t;
   ssp_chk_t st;
   ssp_chk_t next_st;
   logic take;
   logic [6:0] half;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign half = (st.ctl[1:0] == 2'h3) ? 7'h20 : 7'h02 << st.ctl[1:0];
   // ==========
   // control shadow, cycles since the last clock edge, edges per byte
   always_comb begin
      next_st = st;
      next_st.sc = sclk_o;
      next_st.gap = (st.gap == 7'h7f) ? st.gap : st.gap + 7'h01;
      if (sclk_o != st.sc) begin
         next_st.gap = 7'h01;
         next_st.ne = (st.gap > 7'h20) ? 5'h01 : st.ne + 5'h01;
      end
      if (serial_done_irq_o) next_st.ne = 5'h00;
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == IDX_CONTROL) next_st.ctl = wb_dat_i[7:0];
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) st <= {8'h04, 7'h7f, 5'h00, 1'b0};
      else st <= next_st;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_next_a: assert property (take |=> wb_ack_o)
      else $error("ack late");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   irq_pulse_a: assert property (serial_done_irq_o |=> !serial_done_irq_o)
      else $error("done request too long");
   idle_level_a: assert property (serial_done_irq_o && st.ctl[4] |-> sclk_o == st.ctl[3])
      else $error("clock not idle after byte");
   half_period_a: assert property (sclk_o != st.sc && sclk_o == st.ctl[3] && st.ctl[4] && st.gap <= 7'h20 |->
      st.gap == half) else $error("clock half period wrong");
   edge_count_a: assert property (serial_done_irq_o && st.ctl[4] |-> st.ne == 5'h10)
      else $error("edge count wrong");
   ovf_master_a: assert property (take && !wb_we_i && wb_adr_i[7:2] == IDX_STATUS && st.ctl[4] |=>
      wb_dat_o[STS_SLAVE_OVERFLOW_FLAG] == 1'b0) else $error("overflow set in master");
   oe_split_a: assert property (!(sclk_oe_o && miso_oe_o) && mosi_oe_o == sclk_oe_o)
      else $error("enables clash");
   cover property (serial_done_irq_o && st.ctl[4]);
   cover property (serial_done_irq_o && !st.ctl[4]);
   cover property (take && wb_we_i && wb_adr_i[7:2] == IDX_DATA);
endmodule
`default_nettype wire

// file: sim/ssp_peer.sv
// ssp_peer: behavioural serial slave facing the port in master role
// assumes the bench resolves clock and data lines
`timescale 1ns/100ps
`default_nettype none
module ssp_peer (
   // serial lines
   input wire logic sclk_i,
   input wire logic mosi_i,
   input wire logic sel_n_i,
   output logic miso_o,
   // format, reply byte, answer lag in ns
   input wire logic cpol_i,
   input wire logic cpha_i,
   input wire logic lsb_i,
   input wire logic [7:0] reply_i,
   input wire logic [3:0] lag_i,
   output logic [7:0] got_o
);
   int n;
   function automatic logic pick(input int i);
      if (i > 7) return ~miso_o;
      return lsb_i ? reply_i[i] : reply_i[7 - i];
   endfunction
   initial begin
      miso_o = 1'b0;
      got_o = 8'h00;
      n = 0;
   end
   // phase 0 shows the first bit as soon as selected
   always @(negedge sel_n_i) begin
      n = 0;
      if (!cpha_i) miso_o <= #(lag_i) pick(0);
   end
   always @(posedge sel_n_i) miso_o <= ~miso_o;
   always @(sclk_i) begin
      if (!sel_n_i && ((sclk_i != cpol_i) ^ cpha_i)) begin
         got_o = lsb_i ? {mosi_i, got_o[7:1]} : {got_o[6:0], mosi_i};
         n++;
      end else if (!sel_n_i) miso_o <= #(lag_i) pick(n);
   end
endmodule
`default_nettype wire

// file: sim/spi_master_slave_port_bench.sv
// spi_master_slave_port_bench: self-checking bench of the serial port
// assumes ssp_top, ssp_peer and ssp_checker are compiled before it
`timescale 1ns/100ps
`default_nettype none
module spi_master_slave_port_bench;
   import ssp_pkg::*;
   localparam logic [7:0] AS = {IDX_STATUS, 2'h0};
   localparam logic [7:0] AD = {IDX_DATA, 2'h0};
   localparam logic [7:0] AC = {IDX_CONTROL, 2'h0};
   logic clk_i, rst_i, cyc, stb, we, ack, irq, so, soe, mo, moe, io, ioe;
   logic tsc, tmo, ss_n, pm, psel_n, pol, pha, lsb;
   logic [7:0] adr, rep, got, q, tx, c;
   logic [31:0] wd, rd;
   logic [3:0] lag;
   logic [7:0] ra[4] = '{AC, AD, AS, 8'hB0};
   logic [7:0] rv[4] = '{8'h04, 8'h00, 8'h00, 8'h00};
   logic [7:0] eq[$];
   int n_fail, num_checks, nirq, k;
   wire logic sw = soe ? so : tsc;
   wire logic mw = moe ? mo : tmo;
   wire logic iw = ioe ? io : pm;
   ssp_top ssp_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .sclk_i(sw),
      .sclk_o(so), .sclk_oe_o(soe), .mosi_i(mw), .mosi_o(mo), .mosi_oe_o(moe), .miso_i(iw),
      .miso_o(io), .miso_oe_o(ioe), .ss_n_i(ss_n), .serial_done_irq_o(irq));
   ssp_peer ssp_peer_i (.sclk_i(sw), .mosi_i(mw), .sel_n_i(psel_n), .miso_o(pm), .cpol_i(pol),
      .cpha_i(pha), .lsb_i(lsb), .reply_i(rep), .lag_i(lag), .got_o(got));
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   // waits for ack as long as it takes; only the watchdog ends a hung request
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, wd} <= {2'h3, w, a, 24'h0000, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rd[7:0];
      {cyc, stb} <= 2'h0;
   endtask
   task automatic wait_irq();
      int t;
      t = 0;
      do @(posedge clk_i); while (nirq == 0 && ++t < 3000);
      if (t == 3000) n_fail++;
   endtask
   // bench plays an external master: phase 1, polarity 0, msb first
   task automatic ext_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_i);
         {tsc, tmo} <= {1'b1, b[i]};
         repeat (6) @(posedge clk_i);
         tsc <= 1'b0;
         c = {c[6:0], io};
         repeat (5) @(posedge clk_i);
      end
      tmo <= ~tmo;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk_i) if (irq === 1'b1) nirq++;
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      final_report();
   end
   initial begin
      {rst_i, ss_n, psel_n} = 3'h7;
      {cyc, stb, we, tsc, tmo, pol, pha, lsb} = 8'h00;
      {adr, wd, rep, lag, c} = 60'h0;
      k = $urandom(32'hb2fa);
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ra[j]) begin
         wb(1'b0, ra[j], 8'h00);
         chk("reset", q, rv[j]);
      end
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         tx = 8'($urandom);
         rep = 8'($urandom);
         {pol, pha, lsb} = 3'($urandom);
         // released clock line rests at the idle level
         tsc <= pol;
         lag = (i % 4 == 0) ? 4'h0 : 4'($urandom);
         c = {2'h2, lsb, 1'b1, pol, pha, 2'(i)};
         repeat (40) @(posedge clk_i);
         wb(1'b1, AC, c);
         wb(1'b1, AC, c | 8'h40);
         repeat (40) @(posedge clk_i);
         psel_n <= 1'b0;
         wb(1'b1, AD, tx);
         if (i == 0) wb(1'b1, AD, ~tx);
         if (i == 1) wb(1'b1, AC, c);
         wait_irq();
         psel_n <= 1'b1;
         chk("peer rx", got, tx);
         wb(1'b0, AD, 8'h00);
         chk("rx byte", q, rep);
         wb(1'b0, AS, 8'h00);
         chk("status", q, {1'b1, i == 0, 6'h00});
         wb(1'b0, AD, 8'h00);
         wb(1'b0, AS, 8'h00);
         chk("cleared", q, 8'h00);
         chk("irqs", 8'(nirq), 8'h01);
         nirq = 0;
      end
      $display("test master done");
      tsc <= 1'b0;
      wb(1'b1, AC, 8'h84);
      wb(1'b1, AC, 8'hC4);
      wb(1'b1, AD, 8'h5A);
      ss_n <= 1'b0;
      eq.push_back(8'($urandom));
      ext_byte(eq[0]);
      chk("slave tx", c, 8'h5A);
      wait_irq();
      wb(1'b0, AS, 8'h00);
      chk("slave sts", q, 8'h80);
      wb(1'b0, AD, 8'h00);
      chk("slave rx", q, eq.pop_front());
      nirq = 0;
      ss_n <= 1'b1;
      ext_byte(8'hFF);
      repeat (8) @(posedge clk_i);
      wb(1'b0, AS, 8'h00);
      chk("deselected", q, 8'h00);
      ss_n <= 1'b0;
      for (int i = 0; i < 2; i++) ext_byte(8'($urandom));
      repeat (8) @(posedge clk_i);
      wb(1'b0, AS, 8'h00);
      chk("overflow", q, 8'hA0);
      chk("irqs", 8'(nirq), 8'h01);
      wb(1'b1, AC, 8'h94);
      wb(1'b1, AC, 8'h84);
      wb(1'b0, AS, 8'h00);
      chk("ovf cleared", q, 8'h80);
      wb(1'b1, AC, 8'hC0);
      wb(1'b1, AD, 8'h3C);
      wb(1'b0, AS, 8'h00);
      chk("slave write_collision_flag", q, 8'h40);
      $display("test slave done");
      final_report();
   end
endmodule
bind ssp_top ssp_checker #(.ADR_W(ADR_W)) ssp_checker_i (.*);
`default_nettype wire
